// [inc/card_port_regs.svh]
// Behaviour
// - a card reset output forces the inserted card into hard reset
// - card address driven out, released to input while another owner holds it
// - card address is socket address register joined with low 11 bus bits
// - i/o read and write strobes pulse only with attribute select asserted
// - attribute select stays high for ordinary main memory accesses
// - card wait input extends the current memory or i/o cycle
// - active-low output enable gates memory read data from the card
// - write enable gates memory write data into the card
// - first card enable selects even byte lane, second the odd lane
// - active-low socket enable selects socket and external address buffers
// - transceiver direction high for reads, low for writes
// - transceiver direction low from power-up until the first read
// - five power control outputs switch both programming voltages and supply
// - the general purpose input always reads as logic one
`ifndef CARD_PORT_REGS_SVH
`define CARD_PORT_REGS_SVH
`define REG_CTRL        4'h0
`define REG_SOCK_ADDR   4'h1
`define REG_POWER       4'h2
`define REG_STATUS      4'h3
`define REG_DATA        4'h4
`define REG_ACCESS      4'h5
`define CTRL_RESET_BIT  0
`define CTRL_RESET_VAL  8'h01
`define POWER_RESET_VAL 8'h10
`define SYNC_IDLE_VAL   9'h0C7
`define LOW_ADDR_BITS   11
`define SETUP_CYCLES    3'h1
`define STROBE_CYCLES   3'h4
`define HOLD_CYCLES     3'h1
`endif

// [inc/card_port_pkg.sv]
package card_port_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } cycle_state_t;
endpackage

// [hdl/card_port.sv]
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "card_port_regs.svh"
module card_port (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic        bus_owner_i,
  input  wire logic [25:0] card_addr_i,
  output logic      [25:0] card_addr_o,
  output logic             card_addr_oe_o,
  input  wire logic [15:0] card_data_i,
  output logic      [15:0] card_data_o,
  output logic             card_data_oe_o,
  output logic             card_reset_o,
  output logic             card_en_even_n_o,
  output logic             card_en_odd_n_o,
  output logic             mem_rd_n_o,
  output logic             mem_wr_n_o,
  output logic             io_rd_n_o,
  output logic             io_wr_n_o,
  output logic             attr_sel_n_o,
  input  wire logic        wait_n_i,
  input  wire logic        ready_i,
  input  wire logic        write_protect_i,
  input  wire logic        batt_detect1_i,
  input  wire logic        batt_detect2_i,
  input  wire logic        card_detect1_n_i,
  input  wire logic        card_detect2_n_i,
  input  wire logic        spare_input_n_i,
  output logic             socket_iface_select_n_o,
  output logic             xcvr_direction_o,
  output logic             supply_en_n_o,
  output logic             prog_volt1_sel0_o,
  output logic             prog_volt1_sel1_o,
  output logic             prog_volt2_sel0_o,
  output logic             prog_volt2_sel1_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [8:0] pin_meta;
  logic [8:0] pin_sync;
  logic [8:0] pin_raw;

  assign pin_raw = {bus_owner_i, wait_n_i, ready_i, write_protect_i,
                    batt_detect1_i, batt_detect2_i, card_detect1_n_i,
                    card_detect2_n_i, spare_input_n_i};

  // each stage resets to its pin's idle level: no false card or wait
  localparam logic [8:0] sync_idle = `SYNC_IDLE_VAL;

  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_sync
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          pin_meta[gi] <= sync_idle[gi];
          pin_sync[gi] <= sync_idle[gi];
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  logic owner_s;
  logic wait_n_s;
  logic ready_s;
  logic wp_s;
  logic bvd1_s;
  logic bvd2_s;
  logic cd1_n_s;
  logic cd2_n_s;
  assign {owner_s, wait_n_s, ready_s, wp_s, bvd1_s, bvd2_s,
          cd1_n_s, cd2_n_s} = pin_sync[8:1];

  // read data passes the same two stages as the control pins
  logic [15:0] data_meta;
  logic [15:0] data_sync;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      data_meta <= 16'h0000;
      data_sync <= 16'h0000;
    end else begin
      data_meta <= card_data_i;
      data_sync <= data_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  ctrl;
  logic [14:0] sock_addr;
  logic [7:0]  power;
  logic [15:0] wdata;
  logic [15:0] rdata_cap;
  logic        card_seated;
  logic        busy;
  logic        start;
  logic [15:0] acc;

  // access word: [10:0] low address, [11] write, [12] io, [13] attr,
  // [15:14] lane enables (bit14 even, bit15 odd)
  assign start = reg_wr_i && reg_addr_i == `REG_ACCESS && !busy
                 && card_seated && !owner_s;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RESET_VAL;
    end else if (reg_wr_i && reg_addr_i == `REG_CTRL) begin
      ctrl <= reg_wdata_i[7:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sock_addr <= 15'h0000;
    end else if (reg_wr_i && reg_addr_i == `REG_SOCK_ADDR) begin
      sock_addr <= reg_wdata_i[14:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      power <= `POWER_RESET_VAL;
    end else if (reg_wr_i && reg_addr_i == `REG_POWER) begin
      power <= reg_wdata_i[7:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wdata <= 16'h0000;
    end else if (reg_wr_i && reg_addr_i == `REG_DATA) begin
      wdata <= reg_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `REG_CTRL:      reg_rdata_o <= {8'h00, ctrl};
        `REG_SOCK_ADDR: reg_rdata_o <= {1'b0, sock_addr};
        `REG_POWER:     reg_rdata_o <= {8'h00, power};
        `REG_STATUS:    reg_rdata_o <= {7'h00, 1'b1, busy, card_seated,
                                        cd2_n_s, cd1_n_s, bvd2_s, bvd1_s,
                                        wp_s, ready_s};
        `REG_DATA:      reg_rdata_o <= rdata_cap;
        `REG_ACCESS:    reg_rdata_o <= acc;
        default:        reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // socket detect, reset and power
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      card_seated <= 1'b0;
    end else begin
      card_seated <= !cd1_n_s && !cd2_n_s;
    end
  end

  // socket enable follows both detects directly, no debounce
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      socket_iface_select_n_o <= 1'b1;
    end else begin
      socket_iface_select_n_o <= cd1_n_s || cd2_n_s;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      card_reset_o <= 1'b1;
    end else begin
      card_reset_o <= ctrl[`CTRL_RESET_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      supply_en_n_o     <= 1'b1;
      prog_volt1_sel0_o <= 1'b0;
      prog_volt1_sel1_o <= 1'b0;
      prog_volt2_sel0_o <= 1'b0;
      prog_volt2_sel1_o <= 1'b0;
    end else begin
      supply_en_n_o     <= !power[4];
      prog_volt1_sel0_o <= power[0];
      prog_volt1_sel1_o <= power[1];
      prog_volt2_sel0_o <= power[2];
      prog_volt2_sel1_o <= power[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // card cycle sequencer
  card_port_pkg::cycle_state_t state;
  card_port_pkg::cycle_state_t next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic       is_wr;
  logic       is_io;
  logic       is_attr;
  logic       leave_strobe;

  assign busy = state != card_port_pkg::ST_IDLE;
  // wait arrives two cycles after the strobe pin; minimum strobe covers it
  assign leave_strobe = state == card_port_pkg::ST_STROBE && cnt <= 3'h1
                        && wait_n_s;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      card_port_pkg::ST_IDLE: begin
        if (start) begin
          next_cnt   = `SETUP_CYCLES;
          next_state = card_port_pkg::ST_SETUP;
        end
      end
      card_port_pkg::ST_SETUP: begin
        if (cnt == 3'h1) begin
          next_cnt   = `STROBE_CYCLES;
          next_state = card_port_pkg::ST_STROBE;
        end else begin
          next_cnt = cnt - 3'h1;
        end
      end
      card_port_pkg::ST_STROBE: begin
        if (cnt > 3'h1) begin
          next_cnt = cnt - 3'h1;
        end else if (leave_strobe) begin
          next_cnt   = `HOLD_CYCLES;
          next_state = card_port_pkg::ST_HOLD;
        end
      end
      card_port_pkg::ST_HOLD: begin
        if (cnt == 3'h1) begin
          next_state = card_port_pkg::ST_IDLE;
        end else begin
          next_cnt = cnt - 3'h1;
        end
      end
      default: begin
        next_state = card_port_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= card_port_pkg::ST_IDLE;
      cnt   <= 3'h0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // access word held for the whole card cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      acc     <= 16'h0000;
      is_wr   <= 1'b0;
      is_io   <= 1'b0;
      is_attr <= 1'b0;
    end else if (start) begin
      acc     <= reg_wdata_i;
      is_wr   <= reg_wdata_i[11];
      is_io   <= reg_wdata_i[12];
      is_attr <= reg_wdata_i[13] || reg_wdata_i[12];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_cap <= 16'h0000;
    end else if (leave_strobe && !is_wr) begin
      rdata_cap <= data_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // card pins
  logic strobe;
  assign strobe = state == card_port_pkg::ST_STROBE;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      card_addr_o    <= 26'h000_0000;
      card_addr_oe_o <= 1'b0;
      card_data_o    <= 16'h0000;
      card_data_oe_o <= 1'b0;
    end else begin
      card_addr_oe_o <= !owner_s;
      card_addr_o    <= {sock_addr, acc[`LOW_ADDR_BITS-1:0]};
      card_data_o    <= wdata;
      card_data_oe_o <= busy && is_wr && !owner_s;
    end
  end

  // lanes and attribute select span the whole card cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      card_en_even_n_o <= 1'b1;
      card_en_odd_n_o  <= 1'b1;
      attr_sel_n_o     <= 1'b1;
    end else begin
      card_en_even_n_o <= !(busy && acc[14]);
      card_en_odd_n_o  <= !(busy && acc[15]);
      attr_sel_n_o     <= !(busy && is_attr);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mem_rd_n_o <= 1'b1;
      mem_wr_n_o <= 1'b1;
      io_rd_n_o  <= 1'b1;
      io_wr_n_o  <= 1'b1;
    end else begin
      mem_rd_n_o <= !(strobe && !is_io && !is_wr);
      mem_wr_n_o <= !(strobe && !is_io && is_wr);
      io_rd_n_o  <= !(strobe && is_io && is_attr && !is_wr);
      io_wr_n_o  <= !(strobe && is_io && is_attr && is_wr);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      xcvr_direction_o <= 1'b0;
    end else if (busy) begin
      xcvr_direction_o <= !is_wr;
    end
  end

endmodule

// [dv/card_port_checker.sv]
`timescale 1ns/1ps
module card_port_checker (
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        bus_owner_i,
  input wire logic        card_addr_oe_o,
  input wire logic        card_data_oe_o,
  input wire logic        mem_rd_n_o,
  input wire logic        mem_wr_n_o,
  input wire logic        io_rd_n_o,
  input wire logic        io_wr_n_o,
  input wire logic        attr_sel_n_o,
  input wire logic        wait_n_i,
  input wire logic        card_detect1_n_i,
  input wire logic        card_detect2_n_i,
  input wire logic        socket_iface_select_n_o,
  input wire logic        xcvr_direction_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  io_attr_a: assert property ((!io_rd_n_o || !io_wr_n_o) |-> !attr_sel_n_o)
    else $error("io strobe without attribute select");
  rd_dir_a: assert property ((!mem_rd_n_o || !io_rd_n_o) |->
    xcvr_direction_o && !card_data_oe_o) else $error("read direction wrong");
  wr_dir_a: assert property ((!mem_wr_n_o || !io_wr_n_o) |->
    !xcvr_direction_o && card_data_oe_o) else $error("write direction wrong");
  strobe_len_a: assert property ($fell(mem_rd_n_o) |-> !mem_rd_n_o [*4])
    else $error("read strobe too short");
  wait_hold_a: assert property ((!wait_n_i && !mem_rd_n_o) [*5] |=>
    !mem_rd_n_o) else $error("wait ignored");
  addr_rel_a: assert property (bus_owner_i [*6] |-> !card_addr_oe_o)
    else $error("address driven under other owner");
  sock_off_a: assert property ((card_detect1_n_i || card_detect2_n_i) [*5]
    |-> socket_iface_select_n_o) else $error("socket selected without card");
  sock_on_a: assert property ((!card_detect1_n_i && !card_detect2_n_i) [*5]
    |-> !socket_iface_select_n_o) else $error("socket not selected");
  spare_one_a: assert property (reg_rd_i && reg_addr_i == 4'h3 |=>
    reg_rdata_o[8]) else $error("spare input not one");
  cover property (!io_rd_n_o);
  cover property (!mem_wr_n_o);
  cover property (!wait_n_i && !mem_rd_n_o);
  cover property ((!wait_n_i && !mem_rd_n_o) [*5]);
endmodule
bind card_port card_port_checker i_card_port_checker (.*);

// [dv/card_model.sv]
`timescale 1ns/1ps
module card_model (
  input  wire logic        mclk_i,
  input  wire logic [25:0] addr_i,
  input  wire logic        rd_n_i,
  input  wire logic        iord_n_i,
  input  wire logic        attr_n_i,
  input  wire logic [4:0]  stall_i,
  input  wire logic        seated_i,
  input  wire logic        wp_i,
  input  wire logic        batt_ok_i,
  input  wire logic        busy_i,
  output logic      [15:0] data_o,
  output logic             wait_n_o,
  output logic             ready_o,
  output logic             wp_o,
  output logic             bvd1_o,
  output logic             bvd2_o,
  output logic             cd1_n_o,
  output logic             cd2_n_o
);
  logic       tog = 1'b0;
  logic [4:0] cnt = 5'h00;
  logic       drive;
  assign drive = !rd_n_i || (!iord_n_i && !attr_n_i);
  // released bus shows a toggling pattern
  assign data_o = drive ? addr_i[15:0] ^ 16'hA5C3 : {8{tog, ~tog}};
  assign wait_n_o = !(drive && cnt != 5'h00);
  assign ready_o = !busy_i;
  assign wp_o = wp_i;
  assign bvd1_o = batt_ok_i;
  assign bvd2_o = batt_ok_i;
  assign cd1_n_o = !seated_i;
  assign cd2_n_o = !seated_i;
  always_ff @(posedge mclk_i) begin
    tog <= ~tog;
    cnt <= !drive ? stall_i : (cnt == 5'h00 ? cnt : cnt - 5'h01);
  end
endmodule

// [dv/tb_card_port.sv]
`timescale 1ns/1ps
module tb_card_port;
  logic mclk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, bus_owner_i = 0;
  logic [3:0] reg_addr_i = 0;
  logic [15:0] reg_wdata_i = 0, reg_rdata_o, card_data_o, card_data_i;
  logic [25:0] card_addr_o, card_addr_i = 0;
  logic card_addr_oe_o, card_data_oe_o, card_reset_o, card_en_even_n_o;
  logic card_en_odd_n_o, mem_rd_n_o, mem_wr_n_o, io_rd_n_o, io_wr_n_o;
  logic attr_sel_n_o, wait_n_i, ready_i, write_protect_i, batt_detect1_i;
  logic batt_detect2_i, card_detect1_n_i, card_detect2_n_i;
  logic spare_input_n_i = 0, socket_iface_select_n_o, xcvr_direction_o;
  logic supply_en_n_o, prog_volt1_sel0_o, prog_volt1_sel1_o;
  logic prog_volt2_sel0_o, prog_volt2_sel1_o;
  logic [4:0] stall = 0;
  logic seated = 1, wp_s = 0, batt_s = 1, busy_s = 0;
  int failures = 0, compares = 0;
  card_port i_card_port (.*);
  card_model i_card_model (.mclk_i(mclk_i), .addr_i(card_addr_o),
    .rd_n_i(mem_rd_n_o), .iord_n_i(io_rd_n_o), .attr_n_i(attr_sel_n_o),
    .stall_i(stall), .seated_i(seated), .wp_i(wp_s), .batt_ok_i(batt_s),
    .busy_i(busy_s), .data_o(card_data_i), .wait_n_o(wait_n_i),
    .ready_o(ready_i), .wp_o(write_protect_i), .bvd1_o(batt_detect1_i),
    .bvd2_o(batt_detect2_i), .cd1_n_o(card_detect1_n_i),
    .cd2_n_o(card_detect2_n_i));
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [25:0] got, input logic [25:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1; reg_addr_i <= a; reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    reg_rd_i <= 1; reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 0;
    #1 d = reg_rdata_o;
  endtask
  // strobe-time view: {dir, attr_n, even_n, odd_n}, address and write data
  task automatic acc(input logic [15:0] c, output logic [25:0] a,
                     output logic [3:0] s, output logic [15:0] dw);
    wr(4'h5, c);
    s = 4'hF;
    repeat (40) begin
      @(negedge mclk_i);
      if (!(mem_rd_n_o && mem_wr_n_o && io_rd_n_o && io_wr_n_o)) begin
        a = card_addr_o; dw = card_data_o;
        s = {xcvr_direction_o, attr_sel_n_o, card_en_even_n_o, card_en_odd_n_o};
      end
    end
  endtask
  task automatic complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk_i);
    failures++;
    complete_run;
  end
  initial begin
    logic [15:0] d, c, sa, wd, dw;
    logic [25:0] a;
    logic [3:0] s;
    logic [4:0] p;
    void'($urandom(71));
    repeat (12) @(posedge mclk_i);
    rst_i <= 0;
    @(posedge mclk_i);
    #1 chk({card_reset_o, xcvr_direction_o}, 2'b10);
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk_i);
      {wp_s, batt_s, busy_s} <= 3'($urandom);
      repeat (4) @(posedge mclk_i);
      rd(4'h3, d);
      chk(d[8:0], {5'b10100, batt_s, batt_s, wp_s, !busy_s});
    end
    busy_s <= 0;
    rd(4'($urandom_range(15, 6)), d);
    chk(d, 0);
    wr(4'h0, 16'h0000);
    repeat (2) @(posedge mclk_i);
    p = 5'($urandom);
    wr(4'h2, {11'h000, p});
    repeat (2) @(posedge mclk_i);
    #1 chk(card_reset_o, 0);
    chk({~supply_en_n_o, prog_volt2_sel1_o, prog_volt2_sel0_o,
         prog_volt1_sel1_o, prog_volt1_sel0_o}, p);
    $display("register test done");
    for (int i = 0; i < 12; i++) begin
      sa = 16'($urandom) & 16'h7FFF; wd = 16'($urandom); c = 16'($urandom);
      c[12:11] = 2'(i);
      wr(4'h1, sa);
      wr(4'h4, wd);
      stall <= (i == 4) ? 5'h07 : 5'($urandom % 8);
      acc(c, a, s, dw);
      chk(a, {sa[14:0], c[10:0]});
      chk(s, {!c[11], !(c[12] | c[13]), !c[14], !c[15]});
      if (c[11]) chk(dw, wd);
      else begin
        rd(4'h4, d);
        chk(d, {sa[4:0], c[10:0]} ^ 16'hA5C3);
      end
    end
    $display("card cycle test done");
    bus_owner_i <= 1;
    repeat (6) @(posedge mclk_i);
    #1 chk(card_addr_oe_o, 0);
    @(posedge mclk_i);
    bus_owner_i <= 0;
    seated <= 0;
    repeat (6) @(posedge mclk_i);
    #1 chk({card_addr_oe_o, socket_iface_select_n_o}, 2'b11);
    acc(16'h4000, a, s, dw);
    chk(s, 4'hF);
    seated <= 1;
    repeat (6) @(posedge mclk_i);
    #1 chk(socket_iface_select_n_o, 0);
    $display("socket test done");
    complete_run;
  end
endmodule
